/* File: shared/acg_pkg.sv */
// package of register map, field layout and bus carriers for the channel gain block
package acg_pkg;

    // ------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_LOWER = 6'h04; // lower_channel_gain index
    localparam logic [5:0] IDX_UPPER = 6'h05; // upper_channel_gain index
    localparam logic [7:0] ADDR_LOWER = {IDX_LOWER, 2'b00}; // byte address 0x10
    localparam logic [7:0] ADDR_UPPER = {IDX_UPPER, 2'b00}; // byte address 0x14

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int REG_W = 16; // register width
    localparam int CODE_W = 3; // gain code width
    localparam int FIELD_STEP = 4; // distance between channel fields
    localparam int FIELDS_PER_REG = 4; // channel fields in one register
    localparam int NUM_CH = 8; // channels in total
    localparam int GAIN_W = 8; // one-hot gain, bit n set means gain 2**n
    localparam logic [15:0] LOWER_RESET = 16'h0000; // lower register reset
    localparam logic [15:0] UPPER_RESET = 16'h0000; // upper register reset

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic psel; // slave select
        logic penable; // access phase
        logic pwrite; // direction, high for write
        logic [7:0] paddr; // byte address
        logic [31:0] pwdata; // write data
        logic [3:0] pstrb; // write byte lanes
    } acg_apb_req_type;

    typedef struct packed {
        logic pready; // transfer completes
        logic pslverr; // unmapped address
        logic [31:0] prdata; // read data
    } acg_apb_rsp_type;

    typedef logic [NUM_CH-1:0][CODE_W-1:0] acg_codes_type; // code per channel
    typedef logic [NUM_CH-1:0][GAIN_W-1:0] acg_gains_type; // one-hot gain per channel

endpackage

/* File: verilog/acg_gain_regs.sv */
// apb register bank holding the input_amplifier gain codes of eight channels
//
// Operation
// [R01] channel 1 code in lower bits 6:4
// [R02] channel 0 code in lower bits 2:0
// [R03] channel 7 code in upper bits 14:12
// [R04] channel 6 code in upper bits 10:8
// [R05] upper register at index 5, resets zero
// [R06] lower register at index 4, resets zero
// [R07] upper holds channels 5 and 4 codes
// [R08] software writes zero to reserved bits
`timescale 1ns/1ps
`default_nettype none

module acg_gain_regs (
    input wire logic i_clock, // 100 MHz system clock
    input wire logic i_rstn, // synchronous reset, active low
    input wire acg_pkg::acg_apb_req_type i_apb, // apb request from master
    output acg_pkg::acg_apb_rsp_type o_apb, // apb answer, registered
    output acg_pkg::acg_codes_type o_codes, // gain code per channel
    output acg_pkg::acg_gains_type o_gains // one-hot gain per channel
);
    import acg_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // address decode, used by the read path, error flag and writes
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] base);
        hit = (addr == base);
    endfunction

    // merge write data into a register under byte strobes
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        merge = old;
        if (strb[0])
        begin
            merge[7:0] = wd[7:0];
        end
        if (strb[1])
        begin
            merge[15:8] = wd[15:8];
        end
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] lower_channel_gain; // channels 3..0
    logic [15:0] upper_channel_gain; // channels 7..4
    logic ready; // registered pready
    logic slverr; // registered pslverr
    logic [31:0] rdata; // registered prdata
    logic access; // access phase in progress
    logic commit; // edge at which the transfer completes
    logic mapped; // address names a register

    assign access = i_apb.psel & i_apb.penable;
    assign commit = access & ready;
    assign mapped = hit(i_apb.paddr, ADDR_LOWER) | hit(i_apb.paddr, ADDR_UPPER);

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    // one wait state: pready rises in the second access cycle, so
    // read data and error always come from flops
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            ready <= 1'b0;
            slverr <= 1'b0;
            rdata <= 32'h0000_0000;
        end
        else if (access && !ready)
        begin
            ready <= 1'b1;
            slverr <= !mapped;
            if (i_apb.pwrite || !mapped)
            begin
                rdata <= 32'h0000_0000; // writes and holes read zero
            end
            else if (hit(i_apb.paddr, ADDR_LOWER))
            begin
                rdata <= {16'h0000, lower_channel_gain}; // [R06]
            end
            else
            begin
                rdata <= {16'h0000, upper_channel_gain}; // [R05]
            end
        end
        else
        begin
            // answer lasts exactly one cycle
            ready <= 1'b0;
            slverr <= 1'b0;
            rdata <= 32'h0000_0000;
        end
    end

    // one assignment owns the whole answer carrier
    assign o_apb = '{pready: ready, pslverr: slverr, prdata: rdata};

    // ------------------------------------------------------------
    // lower register, channels 0 to 3
    // ------------------------------------------------------------
    // reserved bits are stored as written; they steer no gain, so a
    // careless host cannot disturb a channel through them
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            lower_channel_gain <= LOWER_RESET; // [R06]
        end
        else if (commit && i_apb.pwrite && hit(i_apb.paddr, ADDR_LOWER))
        begin
            // [R01] [R02] fields land at their bit positions
            lower_channel_gain <= merge(lower_channel_gain, i_apb.pwdata, i_apb.pstrb);
        end
    end

    // ------------------------------------------------------------
    // upper register, channels 4 to 7
    // ------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            upper_channel_gain <= UPPER_RESET; // [R05]
        end
        else if (commit && i_apb.pwrite && hit(i_apb.paddr, ADDR_UPPER))
        begin
            // [R03] [R04] [R07] fields land at their bit positions
            upper_channel_gain <= merge(upper_channel_gain, i_apb.pwdata, i_apb.pstrb);
        end
    end

    // ------------------------------------------------------------
    // per-channel codes and one-hot gains
    // ------------------------------------------------------------
    // code n selects gain 2**n; one-hot lags the code by one cycle
    wire acg_codes_type code_net; // codes gathered field by field
    wire acg_gains_type next_gains; // decoded gains, one cycle ahead
    genvar ch;
    generate
        for (ch = 0; ch < FIELDS_PER_REG; ch = ch + 1)
        begin : g_field
            // channel ch from lower, channel ch+4 from upper
            assign code_net[ch] = lower_channel_gain[ch*FIELD_STEP +: CODE_W]; // [R01] [R02]
            assign code_net[ch+FIELDS_PER_REG] =
                upper_channel_gain[ch*FIELD_STEP +: CODE_W]; // [R03] [R04] [R07]
        end
        for (ch = 0; ch < NUM_CH; ch = ch + 1)
        begin : g_gain
            // decoded gain, power of two of the code
            assign next_gains[ch] = 8'h01 << code_net[ch];
        end
    endgenerate

    assign o_codes = code_net;

    // one flop bank for all gains, so a single process owns the output
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            o_gains <= {NUM_CH{8'h01}}; // code zero is unity gain
        end
        else
        begin
            o_gains <= next_gains;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence wr_low_s;
        commit && i_apb.pwrite && i_apb.paddr == ADDR_LOWER && i_apb.pstrb[0];
    endsequence

    sequence wr_up_lo_s;
        commit && i_apb.pwrite && i_apb.paddr == ADDR_UPPER && i_apb.pstrb[0];
    endsequence

    sequence wr_up_hi_s;
        commit && i_apb.pwrite && i_apb.paddr == ADDR_UPPER && i_apb.pstrb[1];
    endsequence

    ch1_field_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R01]
        wr_low_s |=> o_codes[1] == $past(i_apb.pwdata[6:4]))
        else $error("channel 1 code not taken from bits 6:4");

    ch0_field_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R02]
        wr_low_s |=> o_codes[0] == $past(i_apb.pwdata[2:0])
            ##1 o_gains[0] == 8'h01 << $past(o_codes[0]))
        else $error("channel 0 code or gain wrong after write");

    ch7_field_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R03]
        wr_up_hi_s |=> o_codes[7] == $past(i_apb.pwdata[14:12]))
        else $error("channel 7 code not taken from bits 14:12");

    ch6_field_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R04]
        wr_up_hi_s |=> o_codes[6] == $past(i_apb.pwdata[10:8]))
        else $error("channel 6 code not taken from bits 10:8");

    upper_reset_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R05]
        $past(!i_rstn) |-> o_codes[7] == 3'h0 && o_codes[6] == 3'h0 &&
            o_codes[5] == 3'h0 && o_codes[4] == 3'h0)
        else $error("upper channels not at unity gain after reset");

    upper_read_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R05]
        (access && !ready && !i_apb.pwrite && i_apb.paddr == ADDR_UPPER)
            |=> ready && !slverr && rdata == {16'h0000, upper_channel_gain})
        else $error("read at index 5 did not return upper register");

    lower_reset_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R06]
        $past(!i_rstn) |-> lower_channel_gain == 16'h0000 && o_codes[3:0] == 12'h000)
        else $error("lower register not zero after reset");

    ch54_field_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R07]
        wr_up_lo_s |=> o_codes[5] == $past(i_apb.pwdata[6:4]) &&
            o_codes[4] == $past(i_apb.pwdata[2:0]))
        else $error("channel 5 or 4 code misplaced");

endmodule

`default_nettype wire

/* File: test/test_adc_channel_gain_config.sv */
// self-checking testbench for the channel gain register bank
`timescale 1ns/1ps
`default_nettype none

module test_adc_channel_gain_config;
    import acg_pkg::*;

    // ----------------------------------------
    // signals, counters and expected state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] a; // byte address
        logic [31:0] d; // write data
        logic [3:0] s; // byte strobes
        logic [15:0] e; // expected readback
    } acg_row_type;
    logic i_clock = 1'b0; // system clock
    logic i_rstn = 1'b0; // reset, active low
    acg_apb_req_type i_apb = '0; // bus request
    acg_apb_rsp_type o_apb; // bus answer
    acg_codes_type o_codes; // code per channel
    acg_gains_type o_gains; // one-hot gain per channel
    int num_errors = 0; // mismatches
    int checked = 0; // comparisons
    int cycles = 0; // timeout counter
    logic [31:0] rd; // last read data
    logic err; // last slave error
    logic [15:0] lo = 16'h0000; // expected lower register
    logic [15:0] up = 16'h0000; // expected upper register
    // write rows, reserved bits kept zero; readback is what is then held
    acg_row_type rows [12] = '{
        '{ADDR_LOWER, 32'h0000_0070, 4'hf, 16'h0070},
        '{ADDR_LOWER, 32'h0000_0007, 4'hf, 16'h0007},
        '{ADDR_UPPER, 32'h0000_7000, 4'hf, 16'h7000},
        '{ADDR_UPPER, 32'h0000_0700, 4'hf, 16'h0700},
        '{ADDR_UPPER, 32'h0000_0123, 4'hf, 16'h0123},
        '{ADDR_LOWER, 32'h0000_3210, 4'hf, 16'h3210},
        '{ADDR_UPPER, 32'h0000_7654, 4'hf, 16'h7654},
        '{ADDR_UPPER, 32'h0000_7777, 4'hf, 16'h7777},
        '{ADDR_UPPER, 32'h0000_0055, 4'h1, 16'h7755},
        '{ADDR_UPPER, 32'h0000_1200, 4'h2, 16'h1255},
        '{ADDR_LOWER, 32'h0000_4567, 4'hf, 16'h4567},
        '{ADDR_LOWER, 32'h0000_7777, 4'hc, 16'h4567}
    };

    acg_gain_regs DUT (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_apb(i_apb),
        .o_apb(o_apb),
        .o_codes(o_codes),
        .o_gains(o_gains)
    );

    // ----------------------------------------
    // clock and hang guard
    // ----------------------------------------
    initial
    begin
        forever #5 i_clock = ~i_clock;
    end

    // under 150 cycles are needed, so this ceiling only trips on a hang
    always @(posedge i_clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            num_errors++;
            stop_test();
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer, entered at a rising edge; ends one idle cycle later
    // waits for pready as long as it takes; only the hang guard ends a wait
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
        @(posedge i_clock);
        i_apb.penable <= 1'b1;
        @(posedge i_clock);
        while (o_apb.pready !== 1'b1)
        begin
            @(posedge i_clock);
        end
        rd = o_apb.prdata;
        err = o_apb.pslverr;
        i_apb <= '0;
        @(posedge i_clock);
    endtask

    // codes and gains from the expected registers; gains lag one cycle
    task automatic check_outs();
        logic [15:0] r;
        logic [2:0] c;
        @(posedge i_clock);
        for (int n = 0; n < NUM_CH; n++)
        begin
            r = (n < FIELDS_PER_REG) ? lo : up;
            c = r[(n % FIELDS_PER_REG) * FIELD_STEP +: CODE_W];
            chk("channel code", {29'h0, c}, {29'h0, o_codes[n]});
            chk("channel gain", {24'h0, 8'h01 << c}, {24'h0, o_gains[n]});
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (6) @(posedge i_clock);
        i_rstn <= 1'b1;
        @(posedge i_clock);
        chk("pready after reset", 32'h0, {31'h0, o_apb.pready});
        check_outs();
        $display("reset release test done");
        foreach (rows[i])
        begin
            xfer(1'b1, rows[i].a, rows[i].d, rows[i].s);
            if (rows[i].a == ADDR_LOWER)
                lo = rows[i].e;
            else
                up = rows[i].e;
            chk("write error", 32'h0, {31'h0, err});
            xfer(1'b0, rows[i].a, 32'h0, 4'h0);
            chk("readback", {16'h0, rows[i].e}, rd);
            chk("read error", 32'h0, {31'h0, err});
            check_outs();
        end
        $display("table test done");
        // unmapped places must not disturb either register
        xfer(1'b1, 8'h18, 32'h0000_7777, 4'hf);
        chk("unmapped write error", 32'h1, {31'h0, err});
        xfer(1'b0, 8'h0c, 32'h0, 4'h0);
        chk("unmapped read data", 32'h0, rd);
        chk("unmapped read error", 32'h1, {31'h0, err});
        check_outs();
        $display("unmapped test done");
        // reset in mid-run brings every channel back to unity gain
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_rstn <= 1'b1;
        @(posedge i_clock);
        lo = 16'h0000;
        up = 16'h0000;
        chk("pready after mid reset", 32'h0, {31'h0, o_apb.pready});
        xfer(1'b0, ADDR_LOWER, 32'h0, 4'h0);
        chk("lower after reset", 32'h0, rd);
        xfer(1'b0, ADDR_UPPER, 32'h0, 4'h0);
        chk("upper after reset", 32'h0, rd);
        check_outs();
        $display("reset test done");
        stop_test();
    end

endmodule
`default_nettype wire
